// *** hw/pdl_pulse_limit.v ***
// Top of the pulse direction and limit logic of one positioning axis
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`include "pdl_map.vh"
`timescale 1ns/1ns
module pdl_pulse_limit #(
    parameter POS_WIDTH = 32,
    parameter RATE_WIDTH = 16
) (
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire forwardRunInput,
    input wire reverseRunInput,
    input wire inchPlusInput,
    input wire inchMinusInput,
    input wire forwardPrelimitSwitch,
    input wire reversePrelimitSwitch,
    input wire homeProximitySensor,
    input wire handwheelPulse,
    input wire handwheelDir,
    input wire manualOperatingMode,
    output reg forwardPulse,
    output reg reversePulse
);
    localparam ST_IDLE = 2'b00;
    localparam ST_MOVE = 2'b01;
    localparam ST_HOME = 2'b10;

    // Motion source directions, positive is +x/+y sense
    localparam SRC_NONE = 2'b00;
    localparam SRC_POS = 2'b01;
    localparam SRC_NEG = 2'b10;

    wire [8:0] pinSync;
    wire [2:0] ctrlBits;
    wire [15:0] rateDiv;
    wire moveStrobe;
    wire [31:0] moveWord;
    wire posLoadStrobe;
    wire [31:0] posLoadValue;
    wire [31:0] statusWord;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [POS_WIDTH-1:0] position_reg;
    reg [23:0] remain_reg;
    reg [23:0] remain_next;
    reg moveNeg_reg;
    reg moveNeg_next;
    reg [RATE_WIDTH-1:0] rateCnt_reg;
    reg fwdTrip_reg;
    reg revTrip_reg;
    reg homeDone_reg;
    reg handPrev_reg;
    reg [POS_WIDTH-1:0] positionOut;
    // Pulse decision nets, driven further down, read by the state logic
    wire blocked;
    wire fwdPulseReq;
    wire revPulseReq;

    pdl_sync #(
        .WIDTH(9)
    ) pinSyncInst (
        .clk(clk),
        .resetn(resetn),
        .asyncIn({manualOperatingMode, handwheelDir, handwheelPulse, homeProximitySensor,
            reversePrelimitSwitch, forwardPrelimitSwitch, inchMinusInput, inchPlusInput,
            forwardRunInput | reverseRunInput & 1'b0}),
        .syncOut(pinSync)
    );

    // Run inputs have their own two-stage synchroniser, apart from the inch inputs' bank
    reg [1:0] runStage1;
    reg [1:0] runSync;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            runStage1 <= 2'b00;
            runSync <= 2'b00;
        end else begin
            runStage1 <= {reverseRunInput, forwardRunInput};
            runSync <= runStage1;
        end
    end

    wire rotDir = ctrlBits[`PDL_CTRL_ROTDIR];
    wire zrDir = ctrlBits[`PDL_CTRL_ZRDIR];
    wire limPol = ctrlBits[`PDL_CTRL_LIMPOL];
    wire inchPlus = pinSync[1];
    wire inchMinus = pinSync[2];
    wire fwdLimPin = pinSync[3];
    wire revLimPin = pinSync[4];
    wire homeProx = pinSync[5];
    wire handPulse = pinSync[6];
    wire handDir = pinSync[7];
    wire manualMode = pinSync[8];
    wire fwdRun = runSync[0];
    wire revRun = runSync[1];

    // Polarity 0: closed switch trips; polarity 1: open switch trips
    function limitActive;
        input pin;
        input pol;
        begin
            limitActive = pol ? ~pin : pin;
        end
    endfunction

    // Logical direction to physical pulse: 1 means forward pulse
    function toForward;
        input positive;
        input rdir;
        begin
            toForward = positive ^ rdir;
        end
    endfunction

    wire fwdLimNow = limitActive(fwdLimPin, limPol);
    wire revLimNow = limitActive(revLimPin, limPol);
    wire anyTrip = fwdTrip_reg | revTrip_reg;

    // Manual request from run and inch inputs, in logical direction
    reg [1:0] manualSrc;
    always @* begin
        if ((fwdRun | inchPlus) & ~(revRun | inchMinus)) begin
            manualSrc = SRC_POS;
        end else if ((revRun | inchMinus) & ~(fwdRun | inchPlus)) begin
            manualSrc = SRC_NEG;
        end else begin
            manualSrc = SRC_NONE;
        end
    end

    wire handEdge = handPulse & ~handPrev_reg;
    wire rateTick = (rateCnt_reg == {RATE_WIDTH{1'b0}});

    // Home return logical direction: setting 0 is forward at rotDir 0
    wire homePositive = ~zrDir;

    always @* begin
        state_next = state_reg;
        remain_next = remain_reg;
        moveNeg_next = moveNeg_reg;
        case (state_reg)
            ST_IDLE: begin
                if (moveStrobe & moveWord[`PDL_MOVE_HOME]) begin
                    state_next = ST_HOME;
                end else if (moveStrobe & moveWord[`PDL_MOVE_START]) begin
                    state_next = ST_MOVE;
                    remain_next = moveWord[`PDL_MOVE_COUNT_MSB:`PDL_MOVE_COUNT_LSB];
                    moveNeg_next = moveWord[`PDL_MOVE_NEG];
                end
            end
            ST_MOVE: begin
                if ((moveStrobe & moveWord[`PDL_MOVE_STOP]) || remain_reg == 24'h000000) begin
                    state_next = ST_IDLE;
                end else if (fwdPulseReq | revPulseReq) begin
                    remain_next = remain_reg - 24'h000001;
                end else if (blocked) begin
                    state_next = ST_IDLE;
                end
            end
            ST_HOME: begin
                if ((moveStrobe & moveWord[`PDL_MOVE_STOP]) || homeProx || blocked) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Chosen logical direction and its request
    reg wantMove;
    reg wantPositive;
    reg fromHandwheel;
    always @* begin
        wantMove = 1'b0;
        wantPositive = 1'b0;
        fromHandwheel = 1'b0;
        if (state_reg == ST_MOVE) begin
            wantMove = rateTick & (remain_reg != 24'h000000);
            wantPositive = ~moveNeg_reg;
        end else if (state_reg == ST_HOME) begin
            wantMove = rateTick;
            wantPositive = homePositive;
        end else if (manualMode && manualSrc != SRC_NONE) begin
            wantMove = rateTick;
            wantPositive = (manualSrc == SRC_POS);
        end else if (manualMode & handEdge) begin
            wantMove = ~anyTrip;
            wantPositive = handDir;
            fromHandwheel = 1'b1;
        end
    end

    wire wantFwd = toForward(wantPositive, rotDir);
    // A pulse toward a tripped side is refused; away from it is allowed, except handwheel pulses, which any trip stops
    assign blocked = wantFwd ? (fwdTrip_reg | fwdLimNow) : (revTrip_reg | revLimNow);
    assign fwdPulseReq = wantMove & wantFwd & ~blocked;
    assign revPulseReq = wantMove & ~wantFwd & ~blocked;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            remain_reg <= 24'h000000;
            moveNeg_reg <= 1'b0;
            position_reg <= {POS_WIDTH{1'b0}};
            rateCnt_reg <= {RATE_WIDTH{1'b0}};
            fwdTrip_reg <= 1'b0;
            revTrip_reg <= 1'b0;
            homeDone_reg <= 1'b0;
            handPrev_reg <= 1'b0;
            forwardPulse <= 1'b0;
            reversePulse <= 1'b0;
        end else begin
            state_reg <= state_next;
            remain_reg <= remain_next;
            moveNeg_reg <= moveNeg_next;
            handPrev_reg <= handPulse;
            rateCnt_reg <= rateTick ? rateDiv[RATE_WIDTH-1:0] : rateCnt_reg - 1'b1;
            // Trip stays latched until the switch returns to its safe level
            fwdTrip_reg <= fwdLimNow;
            revTrip_reg <= revLimNow;
            if (state_reg == ST_HOME && homeProx) begin
                homeDone_reg <= 1'b1;
            end else if (state_next == ST_HOME) begin
                homeDone_reg <= 1'b0;
            end
            forwardPulse <= fwdPulseReq;
            reversePulse <= revPulseReq;
            if (posLoadStrobe) begin
                position_reg <= posLoadValue[POS_WIDTH-1:0];
            end else if (fwdPulseReq) begin
                position_reg <= rotDir ? position_reg - 1'b1 : position_reg + 1'b1;
            end else if (revPulseReq) begin
                position_reg <= rotDir ? position_reg + 1'b1 : position_reg - 1'b1;
            end
        end
    end

    always @* begin
        positionOut = position_reg;
    end

    assign statusWord = {25'h0, reversePulse, forwardPulse, homeDone_reg,
        (state_reg == ST_HOME), (state_reg != ST_IDLE), revTrip_reg, fwdTrip_reg};

    pdl_apb_slave apbInst (
        .clk(clk),
        .resetn(resetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .statusIn(statusWord),
        .positionIn(positionOut),
        .ctrlBits(ctrlBits),
        .rateDiv(rateDiv),
        .moveStrobe(moveStrobe),
        .moveWord(moveWord),
        .posLoadStrobe(posLoadStrobe),
        .posLoadValue(posLoadValue)
    );
endmodule

// *** hw/pdl_map.vh ***
// Register map, field positions and constants of the pulse direction and limit logic
`ifndef PDL_MAP_VH
`define PDL_MAP_VH
`define PDL_OFF_CTRL 12'h000
`define PDL_OFF_MOVE 12'h004
`define PDL_OFF_STATUS 12'h008
`define PDL_OFF_POS 12'h00C
`define PDL_OFF_RATE 12'h010
`define PDL_OFF_POSLOAD 12'h014
`define PDL_CTRL_ROTDIR 0
`define PDL_CTRL_ZRDIR 1
`define PDL_CTRL_LIMPOL 2
`define PDL_MOVE_START 0
`define PDL_MOVE_NEG 1
`define PDL_MOVE_HOME 2
`define PDL_MOVE_STOP 3
`define PDL_MOVE_COUNT_LSB 8
`define PDL_MOVE_COUNT_MSB 31
`define PDL_CTRL_RESET 3'h0
`define PDL_RATE_RESET 16'h0010
`define PDL_ST_FWDLIM 0
`define PDL_ST_REVLIM 1
`define PDL_ST_BUSY 2
`define PDL_ST_HOMING 3
`define PDL_ST_HOMEDONE 4
`define PDL_ST_FWDPULSE 5
`define PDL_ST_REVPULSE 6
`endif

// *** hw/pdl_sync.v ***
// Two-flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pdl_sync #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire resetn,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1_reg;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1_reg <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule

// *** hw/pdl_apb_slave.v ***
// APB slave register file of the pulse direction and limit logic
`include "pdl_map.vh"
`timescale 1ns/1ns
module pdl_apb_slave (
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [31:0] statusIn,
    input wire [31:0] positionIn,
    output reg [2:0] ctrlBits,
    output reg [15:0] rateDiv,
    output reg moveStrobe,
    output reg [31:0] moveWord,
    output reg posLoadStrobe,
    output reg [31:0] posLoadValue
);
    wire access = psel & penable;
    wire known = (paddr == `PDL_OFF_CTRL) || (paddr == `PDL_OFF_MOVE) ||
        (paddr == `PDL_OFF_STATUS) || (paddr == `PDL_OFF_POS) ||
        (paddr == `PDL_OFF_RATE) || (paddr == `PDL_OFF_POSLOAD);
    reg [31:0] readMux;

    always @* begin
        case (paddr)
            `PDL_OFF_CTRL: readMux = {29'h0, ctrlBits};
            `PDL_OFF_STATUS: readMux = statusIn;
            `PDL_OFF_POS: readMux = positionIn;
            `PDL_OFF_RATE: readMux = {16'h0, rateDiv};
            default: readMux = 32'h00000000;
        endcase
    end

    // Zero wait states: pready is high in every access phase
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b1;
            pslverr <= 1'b0;
            ctrlBits <= `PDL_CTRL_RESET;
            rateDiv <= `PDL_RATE_RESET;
            moveStrobe <= 1'b0;
            moveWord <= 32'h00000000;
            posLoadStrobe <= 1'b0;
            posLoadValue <= 32'h00000000;
        end else begin
            pready <= 1'b1;
            moveStrobe <= 1'b0;
            posLoadStrobe <= 1'b0;
            pslverr <= psel & ~penable & ~known;
            if (psel & ~penable & ~pwrite) begin
                prdata <= readMux;
            end
            if (access & pwrite) begin
                case (paddr)
                    `PDL_OFF_CTRL: ctrlBits <= pwdata[2:0];
                    `PDL_OFF_RATE: rateDiv <= pwdata[15:0];
                    `PDL_OFF_MOVE: begin
                        moveWord <= pwdata;
                        moveStrobe <= 1'b1;
                    end
                    `PDL_OFF_POSLOAD: begin
                        posLoadValue <= pwdata;
                        posLoadStrobe <= 1'b1;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// *** testbench/pdl_pulse_limit_chk.sv ***
// Checker of pulse direction and limit stops at the top ports
`timescale 1ns/1ns
`include "pdl_map.vh"
module pdl_pulse_limit_chk (
    input wire clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire forwardRunInput,
    input wire reverseRunInput,
    input wire inchPlusInput,
    input wire inchMinusInput,
    input wire forwardPrelimitSwitch,
    input wire reversePrelimitSwitch,
    input wire manualOperatingMode,
    input wire forwardPulse,
    input wire reversePulse
);
    logic [2:0] ctrl;
    wire fTrip = forwardPrelimitSwitch ^ ctrl[2];
    wire rTrip = reversePrelimitSwitch ^ ctrl[2];
    wire plus = forwardRunInput | inchPlusInput;
    wire minus = reverseRunInput | inchMinusInput;
    wire man = manualOperatingMode;
    // Shadow of the control word as last written
    always @(posedge clk or negedge resetn) begin
        if (!resetn)
            ctrl <= 3'h0;
        else if (psel && penable && pready && pwrite && paddr == `PDL_OFF_CTRL)
            ctrl <= pwdata[2:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Five cycles cover synchroniser, decision and output register
    sequence plusHeld; (man && plus && !minus && $stable(ctrl))[*5]; endsequence
    sequence minusHeld; (man && minus && !plus && $stable(ctrl))[*5]; endsequence
    a_one_pulse: assert property (!(forwardPulse && reversePulse))
        else $error("two pulses at once");
    a_fwd_closed_stop: assert property ((!ctrl[2] && fTrip)[*6] |-> !forwardPulse)
        else $error("forward pulse past closed limit");
    a_fwd_open_stop: assert property ((ctrl[2] && fTrip)[*6] |-> !forwardPulse)
        else $error("forward pulse past open limit");
    a_rev_limit_stop: assert property (rTrip[*6] |-> !reversePulse)
        else $error("reverse pulse past limit");
    a_plus_dir: assert property (plusHeld |-> !(ctrl[0] ? forwardPulse : reversePulse))
        else $error("plus input wrong pulse");
    a_minus_dir: assert property (minusHeld |-> !(ctrl[0] ? reversePulse : forwardPulse))
        else $error("minus input wrong pulse");
    a_wheel_blocked: assert property ((man && !plus && !minus && (fTrip || rTrip))[*8]
        |-> !forwardPulse && !reversePulse) else $error("motion while tripped");
    a_away_inch: assert property ((man && inchMinusInput && !plus && fTrip && !rTrip
        && !ctrl[0])[*4] |-> ##[0:40] reversePulse) else $error("away inch blocked");
endmodule
bind pdl_pulse_limit pdl_pulse_limit_chk chk (.*);

// *** testbench/pdl_drive_model.sv ***
// Behavioural drive unit with travel limits and home sensor
`timescale 1ns/1ns
module pdl_drive_model #(
    parameter int LIM = 50,
    parameter int HOME = 20
) (
    input wire clk,
    input wire forwardPulse,
    input wire reversePulse,
    input wire normClosed,
    input wire load,
    input wire logic signed [15:0] loadVal,
    output logic signed [15:0] phys,
    output wire fwdSw,
    output wire revSw,
    output wire homeSw
);
    always @(posedge clk) begin
        if (load)
            phys <= loadVal;
        else if (forwardPulse)
            phys <= phys + 16'sd1;
        else if (reversePulse)
            phys <= phys - 16'sd1;
    end
    // Prelimits trip from LIM outward; the modelled position has no hard stop
    assign fwdSw = (phys >= LIM) ^ normClosed;
    assign revSw = (phys <= -LIM) ^ normClosed;
    // Sensor on both sides so a search finds it either way
    assign homeSw = phys >= HOME || phys <= -HOME;
endmodule

// *** testbench/pdl_pulse_limit_tb_top.sv ***
// Self-checking bench of the pulse direction and limit logic
`timescale 1ns/1ns
`include "pdl_map.vh"
module pdl_pulse_limit_tb_top;
    logic clk, resetn, psel, penable, pwrite, wheel, wheelDir, manual, nc, ld, slvErr;
    logic [3:0] runIn;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    logic signed [15:0] ldVal, p0;
    wire [31:0] prdata;
    wire pready, pslverr, fwdP, revP, fSw, rSw, hSw;
    wire signed [15:0] phys;
    int err_count, check_count, cyc;
    pdl_pulse_limit dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .forwardRunInput(runIn[0]), .inchPlusInput(runIn[1]),
        .reverseRunInput(runIn[2]), .inchMinusInput(runIn[3]),
        .forwardPrelimitSwitch(fSw), .reversePrelimitSwitch(rSw),
        .homeProximitySensor(hSw), .handwheelPulse(wheel), .handwheelDir(wheelDir),
        .manualOperatingMode(manual), .forwardPulse(fwdP), .reversePulse(revP));
    pdl_drive_model drv (.clk(clk), .forwardPulse(fwdP), .reversePulse(revP),
        .normClosed(nc), .load(ld), .loadVal(ldVal), .phys(phys), .fwdSw(fSw),
        .revSw(rSw), .homeSw(hSw));
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
        check_count++;
        if (act !== exp) begin
            err_count++;
            $display("[ERR] %0t act %h exp %h", $time, act, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        slvErr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Shaft position from the drive: 1 ahead, 2 behind
    function automatic logic [31:0] sgn(input logic signed [15:0] v);
        return v > 0 ? 32'h1 : v < 0 ? 32'h2 : 32'h0;
    endfunction
    task automatic place(input logic signed [15:0] v);
        @(posedge clk);
        ld <= 1;
        ldVal <= v;
        @(posedge clk);
        ld <= 0;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        {resetn, psel, penable, pwrite, wheel, wheelDir, manual, nc, ld} = 0;
        {runIn, paddr, pwdata, ldVal} = 0;
        place(0);
        resetn <= 1;
        apb(0, `PDL_OFF_RATE, 0);
        cmp(rd, 32'h10);
        apb(1, 12'h0FC, 32'hFF);
        cmp({31'h0, slvErr}, 32'h1);
        // Rate 1, one tick every two cycles, keeps the run short
        apb(1, `PDL_OFF_RATE, 1);
        for (int k = 0; k < 8; k++) begin
            apb(1, `PDL_OFF_CTRL, k[1:0]);
            place(0);
            if (k < 4) begin
                apb(1, `PDL_OFF_POSLOAD, 32'h100);
                apb(1, `PDL_OFF_MOVE, {24'd5, 6'h0, k[1], 1'b1});
            end else
                apb(1, `PDL_OFF_MOVE, 32'h4);
            do apb(0, `PDL_OFF_STATUS, 0); while (rd[`PDL_ST_BUSY]);
            cmp(sgn(phys), k[1] == k[0] ? 32'h1 : 32'h2);
            if (k < 4) begin
                apb(0, `PDL_OFF_POS, 0);
                cmp(rd, k[1] ? 32'hFB : 32'h105);
            end else
                cmp(rd[`PDL_ST_HOMEDONE], 1);
        end
        manual <= 1;
        for (int k = 0; k < 8; k++) begin
            apb(1, `PDL_OFF_CTRL, k[0]);
            place(0);
            runIn <= 4'h1 << k[2:1];
            repeat (30) @(posedge clk);
            runIn <= 0;
            repeat (8) @(posedge clk);
            cmp(sgn(phys), (k[2] ^ k[0]) ? 32'h2 : 32'h1);
        end
        for (int k = 0; k < 2; k++) begin
            apb(1, `PDL_OFF_CTRL, k << 2);
            nc <= k[0];
            place(45);
            runIn <= 4'h1;
            repeat (40) @(posedge clk);
            runIn <= 0;
            repeat (8) @(posedge clk);
            cmp(phys >= 50 && phys <= 53, 1);
            apb(0, `PDL_OFF_STATUS, 0);
            cmp(rd[`PDL_ST_FWDLIM], 1);
            p0 = phys;
            repeat (8) begin
                @(posedge clk) wheel <= ~wheel;
                repeat (3) @(posedge clk);
            end
            cmp(phys, p0);
            runIn <= 4'h8;
            repeat (30) @(posedge clk);
            runIn <= 0;
            cmp(phys < p0, 1);
        end
        end_of_test();
    end
endmodule
